// File: lcd_user_char_ram_pkg.sv
// Package for the character LCD generator and format controller.
// Assumes one 20 MHz clock shared by both ends.
package lcd_user_char_ram_pkg;
    localparam int          CLK_HZ            = 20000000;
    localparam int          INIT_TIME_US      = 2000;
    localparam int          INIT_CYCLES       = (INIT_TIME_US * (CLK_HZ / 1000000));
    localparam int          EXEC_CYCLES       = 3;
    localparam int          CLEAR_CYCLES      = 165;
    localparam int          TEXT_RAM_DEPTH    = 128;
    localparam logic [7:0]  OP_CLEAR          = 8'h01;
    localparam logic [7:0]  OP_FUNC_DEFAULT   = 8'h30;
    localparam logic [7:0]  OP_DISP_DEFAULT   = 8'h08;
    localparam logic [7:0]  OP_ENTRY_DEFAULT  = 8'h06;
    localparam logic [7:0]  SPACE_CODE        = 8'h20;
    localparam int          FUNC_MARK_BIT     = 5;
    localparam int          FUNC_WIDTH_BIT    = 4;
    localparam int          FUNC_N_BIT        = 3;
    localparam int          FUNC_M_BIT        = 2;
    localparam int          FUNC_G_BIT        = 1;
    localparam logic [1:0]  FMT_1X24_MUX16    = 2'b00;
    localparam logic [1:0]  FMT_2X24_MUX32    = 2'b10;
    localparam logic [1:0]  FMT_4X12_MUX32    = 2'b11;
endpackage

// File: lcd_link_if.sv
// Instruction link between the microcontroller end and the controller end.
// Assumes both ends share i_mclk; one-cycle strobes.
interface lcd_link_if;
    logic       wr;
    logic       rd;
    logic       rs;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       rvalid;
    logic       busy;
    modport dev (input wr, rd, rs, wdata, output rdata, rvalid, busy);
    modport host (output wr, rd, rs, wdata, input rdata, rvalid, busy);
endinterface

// File: lcd_user_char_ram_ctrl.sv
// Controller end: instruction decode, address counter, user_char_ram addressing,
// dot row generation and power-on initialisation.
// Assumes the host keeps to the busy handshake on lcd_link_if.
// Behaviour
// - Code bits 0-3 form user RAM address 3-6
// - Address bits 0-2 pick pattern row
// - Eighth row ORed with cursor underline
// - Data bit 4 is leftmost column
// - Upper code nibble zero selects user RAM
// - One bit lights a dot
// - Set user RAM address loads bits 0-5
// - Status read returns all seven counter bits
// - Both line bits clear select 1:16
// - 1:16 uses nonstandard wrap on data write/read
// - N=1, M=0 gives 2x24 at 1:32
// - N=1, M=1 gives 4x12 at 1:32
// - Power-up starts with clear display
// - Reset selects 8-bit, one-line, G clear
// - Reset turns display, cursor, blink off
// - Reset entry mode increments
// - Reset points counter at display RAM
// - Busy for 2 ms during initialisation
// - Software initialisation also accepted
// - Function set layout below bit 5 mark
// - Ignore instructions while busy except status
module lcd_user_char_ram_ctrl
    import lcd_user_char_ram_pkg::*;
#(
    parameter int INIT_CNT = INIT_CYCLES
) (
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    lcd_link_if.dev         link,
    input  wire logic [7:0] i_char_code,
    input  wire logic [2:0] i_row,
    input  wire logic       i_at_cursor,
    output logic      [4:0] o_dots,
    output logic            o_rom_sel,
    output logic      [7:0] o_rom_code,
    output logic            o_mux32,
    output logic      [1:0] o_lines_fmt,
    output logic            o_disp_on,
    output logic            o_cursor_on,
    output logic            o_blink_on,
    output logic            o_serial_rst
);
    if (INIT_CNT < TEXT_RAM_DEPTH) begin : g_init_cnt_check
        $error("INIT_CNT must cover the whole text RAM clear");
    end

    typedef enum logic [2:0] {
        ST_INIT  = 3'b000,
        ST_CLEAR = 3'b001,
        ST_SERR  = 3'b010,
        ST_IDLE  = 3'b011,
        ST_EXEC  = 3'b100
    } state_t;

    state_t     state;
    logic [31:0] cnt;
    logic [6:0] address_counter;
    logic       to_user_ram;
    logic       interface_width_bit;
    logic       line_n;
    logic       line_m;
    logic       gen_bit;
    logic       inc_dir;
    logic       shift_en;
    logic       disp_on;
    logic       cur_on;
    logic       blink_on;
    logic [6:0] clr_addr;
    logic [4:0] user_char_ram [0:127];
    logic [7:0] display_text_ram [0:TEXT_RAM_DEPTH-1];
    logic       busy_indicator;
    logic       accept;
    logic       power_up;

    function automatic logic [6:0] wrap_next(input logic [6:0] a, input logic up,
                                             input logic n);
        logic [6:0] r;
        r = up ? a + 7'h01 : a - 7'h01;
        if (!n) begin
            if (up && a == 7'h4f) r = 7'h00;
            if (!up && a == 7'h00) r = 7'h4f;
        end else begin
            if (up && a == 7'h27) r = 7'h40;
            if (up && a == 7'h67) r = 7'h00;
            if (!up && a == 7'h40) r = 7'h27;
            if (!up && a == 7'h00) r = 7'h67;
        end
        return r;
    endfunction

    assign busy_indicator = (state != ST_IDLE);
    assign link.busy      = busy_indicator;
    assign accept         = link.wr && !busy_indicator;

    // Sequencing: defaults, clear, serial reset, then idle
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state <= ST_INIT;
            cnt   <= '0;
        end else begin
            case (state)
                ST_INIT: begin
                    cnt   <= '0;
                    state <= ST_CLEAR;
                end
                ST_CLEAR: begin
                    cnt <= cnt + 32'd1;
                    if (cnt >= 32'(INIT_CNT - 1)) state <= power_up ? ST_SERR : ST_IDLE;
                end
                ST_SERR: state <= ST_IDLE;
                ST_IDLE: begin
                    cnt <= '0;
                    if (accept && !link.rs && link.wdata == OP_CLEAR) state <= ST_CLEAR;
                    else if (accept) state <= ST_EXEC;
                end
                ST_EXEC: begin
                    cnt <= cnt + 32'd1;
                    if (cnt >= 32'(EXEC_CYCLES - 1)) state <= ST_IDLE;
                end
                default: state <= ST_INIT;
            endcase
        end
    end

    assign o_serial_rst = (state == ST_SERR);

    // Serial receiver reset ends power-on initialisation only
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) power_up <= 1'b1;
        else if (state == ST_SERR) power_up <= 1'b0;
    end

    // Clear sweep of display RAM
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            clr_addr <= '0;
        end else if (state == ST_CLEAR) begin
            clr_addr <= clr_addr + 7'h01;
        end else begin
            clr_addr <= '0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (state == ST_CLEAR) begin
            display_text_ram[clr_addr] <= SPACE_CODE;
        end else if (accept && link.rs && !to_user_ram) begin
            display_text_ram[address_counter] <= link.wdata;
        end
        if (accept && link.rs && to_user_ram) begin
            user_char_ram[address_counter] <= link.wdata[4:0];
        end
    end

    // Format and display state
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            interface_width_bit <= 1'b1;
            line_n              <= 1'b0;
            line_m              <= 1'b0;
            gen_bit             <= 1'b0;
            disp_on             <= 1'b0;
            cur_on              <= 1'b0;
            blink_on            <= 1'b0;
            inc_dir             <= 1'b1;
            shift_en            <= 1'b0;
        end else if (state == ST_INIT) begin
            interface_width_bit <= OP_FUNC_DEFAULT[FUNC_WIDTH_BIT];
            line_n              <= OP_FUNC_DEFAULT[FUNC_N_BIT];
            line_m              <= OP_FUNC_DEFAULT[FUNC_M_BIT];
            gen_bit             <= OP_FUNC_DEFAULT[FUNC_G_BIT];
            disp_on             <= OP_DISP_DEFAULT[2];
            cur_on              <= OP_DISP_DEFAULT[1];
            blink_on            <= OP_DISP_DEFAULT[0];
            inc_dir             <= OP_ENTRY_DEFAULT[1];
        end else if (accept && !link.rs) begin
            if (link.wdata == OP_CLEAR) begin
                inc_dir <= 1'b1;
            end else if (link.wdata[7:FUNC_MARK_BIT] == 3'b001 && !link.wdata[0]) begin
                interface_width_bit <= link.wdata[FUNC_WIDTH_BIT];
                line_n              <= link.wdata[FUNC_N_BIT];
                line_m              <= link.wdata[FUNC_M_BIT];
                gen_bit             <= link.wdata[FUNC_G_BIT];
            end else if (link.wdata[7:3] == 5'b00001) begin
                disp_on  <= link.wdata[2];
                cur_on   <= link.wdata[1];
                blink_on <= link.wdata[0];
            end else if (link.wdata[7:2] == 6'b000001) begin
                inc_dir  <= link.wdata[1];
                shift_en <= link.wdata[0];
            end
        end
    end

    // Address counter
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            address_counter <= '0;
            to_user_ram     <= 1'b0;
        end else if (state == ST_INIT || state == ST_CLEAR) begin
            address_counter <= '0;
            to_user_ram     <= 1'b0;
        end else if (accept && !link.rs) begin
            if (link.wdata[7]) begin
                address_counter <= link.wdata[6:0];
                to_user_ram     <= 1'b0;
            end else if (link.wdata[7:6] == 2'b01) begin
                address_counter[5:0] <= link.wdata[5:0];
                to_user_ram          <= 1'b1;
            end else if (link.wdata == 8'h02) begin
                address_counter <= '0;
                to_user_ram     <= 1'b0;
            end
        end else if ((accept && link.rs) || (link.rd && link.rs && !busy_indicator)) begin
            if (to_user_ram) begin
                address_counter <= inc_dir ? address_counter + 7'h01
                                           : address_counter - 7'h01;
            end else begin
                address_counter <= wrap_next(address_counter, inc_dir, line_n);
            end
        end
    end

    // Read port
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            link.rdata  <= '0;
            link.rvalid <= 1'b0;
        end else begin
            link.rvalid <= link.rd;
            if (link.rd && !link.rs) begin
                link.rdata <= {busy_indicator, address_counter};
            end else if (link.rd) begin
                link.rdata <= to_user_ram ? {3'b000, user_char_ram[address_counter]}
                                          : display_text_ram[address_counter];
            end
        end
    end

    // Dot row generation
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_dots     <= '0;
            o_rom_sel  <= 1'b0;
            o_rom_code <= '0;
        end else begin
            if (i_char_code[7:4] == 4'h0) begin
                // Bit 4 leftmost, a one lights the dot
                o_dots <= user_char_ram[{i_char_code[3:0], i_row}]
                          | ((i_row == 3'd7 && i_at_cursor && cur_on) ? 5'h1f : 5'h00);
                o_rom_sel <= 1'b0;
            end else begin
                o_dots    <= ((i_row == 3'd7 && i_at_cursor && cur_on) ? 5'h1f : 5'h00);
                o_rom_sel <= 1'b1;
            end
            o_rom_code <= i_char_code;
        end
    end

    assign o_mux32     = line_n;
    assign o_lines_fmt = {line_n, line_m};
    assign o_disp_on   = disp_on;
    assign o_cursor_on = cur_on;
    assign o_blink_on  = blink_on;
endmodule // lcd_user_char_ram_ctrl

// File: lcd_host_end.sv
// Microcontroller end: turns user commands into link strobes, honours busy.
// Assumes the controller end on lcd_link_if and the same clock.
module lcd_host_end
    import lcd_user_char_ram_pkg::*;
#(
    parameter int INIT_CNT = INIT_CYCLES
) (
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    lcd_link_if.host        link,
    input  wire logic       i_cmd_valid,
    input  wire logic       i_cmd_rs,
    input  wire logic [7:0] i_cmd_data,
    input  wire logic       i_rd_req,
    input  wire logic       i_rd_rs,
    output logic            o_cmd_ready,
    output logic      [7:0] o_rd_data,
    output logic            o_rd_valid
);
    if (INIT_CNT < 1) begin : g_init_cnt_check
        $error("INIT_CNT must be positive");
    end

    logic [31:0] wait_cnt;
    logic        waited;

    // Start-up wait, busy is also honoured
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            wait_cnt <= '0;
            waited   <= 1'b0;
        end else if (!waited) begin
            wait_cnt <= wait_cnt + 32'd1;
            if (wait_cnt >= 32'(INIT_CNT - 1)) waited <= 1'b1;
        end
    end

    assign o_cmd_ready = waited && !link.busy && !link.wr;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            link.wr    <= 1'b0;
            link.rd    <= 1'b0;
            link.rs    <= 1'b0;
            link.wdata <= '0;
        end else begin
            link.wr <= i_cmd_valid && o_cmd_ready;
            link.rd <= i_rd_req && !i_cmd_valid;
            if (i_cmd_valid && o_cmd_ready) begin
                link.rs    <= i_cmd_rs;
                link.wdata <= i_cmd_data;
            end else if (i_rd_req) begin
                link.rs <= i_rd_rs;
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_rd_data  <= '0;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= link.rvalid;
            if (link.rvalid) o_rd_data <= link.rdata;
        end
    end
endmodule // lcd_host_end

// File: lcd_user_char_ram_mux_reset_ctrl_asserts.sv
// Checker on the instruction link between host end and controller end.
// Assumes one clock and an async active-high reset; instantiated beside the link.
module lcd_user_char_ram_mux_reset_ctrl_asserts #(
    parameter int INIT_CNT = 50
) (
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic       i_rs,
    input  wire logic [7:0] i_wdata,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rvalid,
    input  wire logic       i_busy
);
    logic [15:0] since_rst;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    // Cycles since reset release, saturating
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            since_rst <= 16'h0000;
        end else if (since_rst != 16'hffff) begin
            since_rst <= since_rst + 16'h0001;
        end
    end

    property p_init_busy; since_rst < 16'(INIT_CNT) |-> i_busy; endproperty
    a_init_busy: assert property (p_init_busy) else $error("busy low in init");
    property p_init_ends; since_rst == 16'(INIT_CNT + 8) |-> !i_busy; endproperty
    a_init_ends: assert property (p_init_ends) else $error("init never ends");
    property p_rd_answer; i_rd |=> i_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read unanswered");
    property p_rvalid_cause; i_rvalid |-> $past(i_rd); endproperty
    a_rvalid_cause: assert property (p_rvalid_cause) else $error("stray rvalid");
    property p_status_busy; i_rd && !i_rs |=> i_rdata[7] == $past(i_busy); endproperty
    a_status_busy: assert property (p_status_busy) else $error("busy bit wrong");
    property p_rdata_hold; !i_rd |=> $stable(i_rdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
    property p_exec;
        i_wr && !i_busy && !(!i_rs && i_wdata == 8'h01) |=> i_busy [*3] ##1 !i_busy;
    endproperty
    a_exec: assert property (p_exec) else $error("exec busy length wrong");
    property p_clear_long;
        i_wr && !i_busy && !i_rs && i_wdata == 8'h01 |=> i_busy [*8];
    endproperty
    a_clear_long: assert property (p_clear_long) else $error("clear busy short");
endmodule // lcd_user_char_ram_mux_reset_ctrl_asserts

// File: lcd_user_char_ram_mux_reset_ctrl_bench.sv
// Testbench: host end and controller end joined by the link, driven from the host side.
// Assumes package, interface, both ends and the checker compile first.
module lcd_user_char_ram_mux_reset_ctrl_bench;
    import lcd_user_char_ram_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int INIT_SIM = 160;
    logic       i_mclk     = 1'b0;
    logic       i_rst      = 1'b1;
    logic       cmd_valid  = 1'b0;
    logic       cmd_rs     = 1'b0;
    logic [7:0] cmd_data   = 8'h00;
    logic       rd_req     = 1'b0;
    logic       rd_rs      = 1'b0;
    logic [7:0] char_code  = 8'h00;
    logic [2:0] row        = 3'h0;
    logic       at_cursor  = 1'b0;
    logic       cmd_ready, rd_valid, rom_sel, mux32, disp_on, cursor_on, blink_on, serial_rst;
    logic [7:0] rd_data, rom_code;
    logic [4:0] dots;
    logic [1:0] lines_fmt;
    logic [1:0] fmts [3] = '{FMT_1X24_MUX16, FMT_2X24_MUX32, FMT_4X12_MUX32};
    int         miscompares = 0;
    int         n_checks = 0;
    int         serial_pulses = 0;

    always #25 i_mclk = ~i_mclk;

    lcd_link_if link ();
    lcd_user_char_ram_ctrl #(.INIT_CNT(INIT_SIM)) i_lcd_user_char_ram_ctrl (
        .i_mclk(i_mclk), .i_rst(i_rst), .link(link), .i_char_code(char_code), .i_row(row),
        .i_at_cursor(at_cursor), .o_dots(dots), .o_rom_sel(rom_sel), .o_rom_code(rom_code),
        .o_mux32(mux32), .o_lines_fmt(lines_fmt), .o_disp_on(disp_on),
        .o_cursor_on(cursor_on), .o_blink_on(blink_on), .o_serial_rst(serial_rst));
    lcd_host_end #(.INIT_CNT(INIT_SIM)) i_lcd_host_end (
        .i_mclk(i_mclk), .i_rst(i_rst), .link(link), .i_cmd_valid(cmd_valid),
        .i_cmd_rs(cmd_rs), .i_cmd_data(cmd_data), .i_rd_req(rd_req), .i_rd_rs(rd_rs),
        .o_cmd_ready(cmd_ready), .o_rd_data(rd_data), .o_rd_valid(rd_valid));
    lcd_user_char_ram_mux_reset_ctrl_asserts #(.INIT_CNT(INIT_SIM)) i_lcd_user_char_ram_mux_reset_ctrl_asserts (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_wr(link.wr), .i_rd(link.rd), .i_rs(link.rs),
        .i_wdata(link.wdata), .i_rdata(link.rdata), .i_rvalid(link.rvalid),
        .i_busy(link.busy));

    always @(negedge i_mclk) begin
        if (serial_rst === 1'b1) begin
            serial_pulses++;
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wait_high(ref logic s);
        int n;
        n = 0;
        do begin
            @(negedge i_mclk);
            n++;
        end while (s !== 1'b1 && n < 500);
        if (s !== 1'b1) begin
            miscompares++;
            conclude();
        end
    endtask

    task automatic send(input logic rs, input logic [7:0] d);
        wait_high(cmd_ready);
        @(posedge i_mclk);
        cmd_valid <= 1'b1;
        cmd_rs <= rs;
        cmd_data <= d;
        @(posedge i_mclk);
        cmd_valid <= 1'b0;
    endtask

    // Status read; idle waits until the controller is free first
    task automatic status(input logic idle, input logic [7:0] exp);
        if (idle) begin
            wait_high(cmd_ready);
        end
        @(posedge i_mclk);
        rd_req <= 1'b1;
        rd_rs <= 1'b0;
        @(posedge i_mclk);
        rd_req <= 1'b0;
        wait_high(rd_valid);
        check(rd_data, exp);
    endtask

    task automatic pix(input logic [7:0] c, input logic [2:0] r, input logic cur);
        @(posedge i_mclk);
        char_code <= c;
        row <= r;
        at_cursor <= cur;
        repeat (3) @(negedge i_mclk);
    endtask

    initial begin
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(negedge i_mclk);
        check({7'h0, link.busy}, 8'h01);
        check({5'h0, disp_on, cursor_on, blink_on}, 8'h00);
        check({6'h0, lines_fmt}, 8'h00);
        check({7'h0, mux32}, 8'h00);
        repeat (INIT_SIM - 5) @(negedge i_mclk);
        check({7'h0, link.busy}, 8'h01);
        wait_high(cmd_ready);
        check(8'(serial_pulses), 8'h01);
        status(1'b1, 8'h00);
        send(1'b1, 8'h41);
        status(1'b1, 8'h01);
        send(1'b0, 8'hc0);
        send(1'b0, 8'h45);
        status(1'b1, 8'h45);
        send(1'b0, 8'h80);
        send(1'b0, 8'h7f);
        status(1'b1, 8'h3f);
        send(1'b1, 8'h00);
        status(1'b1, 8'h40);
        // Character 3: row 2 and cursor row; counter bit 6 cleared first
        send(1'b0, 8'h80);
        send(1'b0, 8'h5a);
        send(1'b1, 8'h19);
        send(1'b0, 8'h5f);
        send(1'b1, 8'h04);
        send(1'b0, 8'h0f);
        wait_high(cmd_ready);
        check({5'h0, disp_on, cursor_on, blink_on}, 8'h07);
        pix(8'h03, 3'h2, 1'b0);
        check({3'h0, dots}, 8'h19);
        check({7'h0, rom_sel}, 8'h00);
        pix(8'h03, 3'h7, 1'b0);
        check({3'h0, dots}, 8'h04);
        pix(8'h03, 3'h7, 1'b1);
        check({3'h0, dots}, 8'h1f);
        pix(8'h13, 3'h2, 1'b0);
        check({7'h0, rom_sel}, 8'h01);
        check(rom_code, 8'h13);
        for (int k = 0; k < 3; k++) begin
            send(1'b0, {4'h3, fmts[k], 2'b00});
            wait_high(cmd_ready);
            check({6'h0, lines_fmt}, {6'h0, fmts[k]});
            check({7'h0, mux32}, {7'h0, fmts[k][1]});
        end
        send(1'b0, 8'h38);
        send(1'b0, 8'ha7);
        send(1'b1, 8'h41);
        status(1'b1, 8'h40);
        send(1'b0, 8'h30);
        send(1'b0, 8'hcf);
        send(1'b1, 8'h41);
        status(1'b1, 8'h00);
        send(1'b0, 8'h85);
        send(1'b0, 8'h01);
        status(1'b0, 8'h80);
        status(1'b1, 8'h00);
        check(8'(serial_pulses), 8'h01);
        // Mid-run reset with a non-default format and the display on
        send(1'b0, 8'h3c);
        wait_high(cmd_ready);
        @(posedge i_mclk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(negedge i_mclk);
        check({7'h0, link.busy}, 8'h01);
        check({5'h0, disp_on, cursor_on, blink_on}, 8'h00);
        check({6'h0, lines_fmt}, 8'h00);
        wait_high(cmd_ready);
        check(8'(serial_pulses), 8'h02);
        status(1'b1, 8'h00);
        conclude();
    end
endmodule // lcd_user_char_ram_mux_reset_ctrl_bench
